// ---- include/rsx_pkg.sv ----
// Constants shared by the rotate/swap/xor/direction-load datapath
package rsx_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 5;
    // Operation select codes driven by the instruction decoder
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_RRC   = 3'b001,
        OP_NSWAP = 3'b010,
        OP_XORF  = 3'b011,
        OP_XORK  = 3'b100,
        OP_DIRLD = 3'b101
    } op_e;
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic [7:0] DIR_RESET  = 8'hFF;
    localparam logic [4:0] DIR_PORT_A = 5'h06;
    localparam logic [4:0] DIR_PORT_B = 5'h07;
    localparam logic       DEST_ACC   = 1'b0;
    localparam logic       DEST_FILE  = 1'b1;
    localparam int unsigned FILE_DEPTH = 32;
endpackage : rsx_pkg

// ---- src/rsx_alu.sv ----
// Combinational result and flag logic for the datapath
`timescale 1ns/10ps
module rsx_alu (
    input  wire logic [2:0] op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] fval,
    input  wire logic [7:0] lit,
    input  wire logic       carry_in,
    output logic      [7:0] result,
    output logic            carry_out,
    output logic            zero_out
);
    // One result per operation; flags only meaningful where the op uses them
    always_comb begin
        result    = 8'h00;
        carry_out = carry_in;
        case (rsx_pkg::op_e'(op))
            rsx_pkg::OP_RRC: begin
                result    = {carry_in, fval[7:1]};
                carry_out = fval[0];
            end
            rsx_pkg::OP_NSWAP: result = {fval[3:0], fval[7:4]};
            rsx_pkg::OP_XORF:  result = acc ^ fval;
            rsx_pkg::OP_XORK:  result = acc ^ lit;
            default:           result = 8'h00;
        endcase
        zero_out = (result == 8'h00);
    end
endmodule : rsx_alu

// ---- src/rsx_core.sv ----
// Execution datapath: rotate, nibble swap, xor and direction load
`timescale 1ns/10ps
module rsx_core (
    input  wire logic       REF_CLK,
    input  wire logic       RSTN,
    input  wire logic       EXEC,
    input  wire logic [2:0] OP,
    input  wire logic [4:0] FADDR,
    input  wire logic       DEST,
    input  wire logic [7:0] LIT,
    output logic      [7:0] ACC,
    output logic            CARRY,
    output logic            ZERO,
    output logic      [7:0] DIR_A,
    output logic      [7:0] DIR_B,
    output logic      [7:0] FDATA
);
    logic       rst_s1_ff;
    logic       rst_n_ff;
    logic [7:0] acc_ff;
    logic       carry_ff;
    logic       zero_ff;
    logic [7:0] dir_a_ff;
    logic [7:0] dir_b_ff;
    logic [7:0] fdata_ff;
    logic [7:0] file_ff [rsx_pkg::FILE_DEPTH];
    logic [7:0] result;
    logic       nxt_carry;
    logic       nxt_zero;
    logic       res_op;
    logic       to_file;
    logic       to_acc;

    // Reset release through two flops so every register leaves reset together
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    rsx_alu u_alu (
        .op        (OP),
        .acc       (acc_ff),
        .fval      (file_ff[FADDR]),
        .lit       (LIT),
        .carry_in  (carry_ff),
        .result    (result),
        .carry_out (nxt_carry),
        .zero_out  (nxt_zero)
    );

    // Which ops produce a result, and where it lands
    assign res_op  = EXEC && (OP == rsx_pkg::OP_RRC || OP == rsx_pkg::OP_NSWAP
                              || OP == rsx_pkg::OP_XORF);
    assign to_file = res_op && (DEST == rsx_pkg::DEST_FILE);
    assign to_acc  = (res_op && (DEST == rsx_pkg::DEST_ACC))
                     || (EXEC && OP == rsx_pkg::OP_XORK);

    // Accumulator
    always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            acc_ff <= rsx_pkg::ACC_RESET;
        end else if (to_acc) begin
            acc_ff <= result;
        end
    end

    // File registers; one generate entry per address
    genvar gi;
    generate
        for (gi = 0; gi < rsx_pkg::FILE_DEPTH; gi++) begin : g_file
            always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    file_ff[gi] <= 8'h00;
                end else if (to_file && FADDR == 5'(gi)) begin
                    file_ff[gi] <= result;
                end
            end
        end
    endgenerate

    // Carry: only rotate touches it
    always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            carry_ff <= 1'b0;
        end else if (EXEC && OP == rsx_pkg::OP_RRC) begin
            carry_ff <= nxt_carry;
        end
    end

    // Zero: xor ops only; swap and direction load leave it alone
    always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            zero_ff <= 1'b0;
        end else if (EXEC && (OP == rsx_pkg::OP_XORF
                              || OP == rsx_pkg::OP_XORK)) begin
            zero_ff <= nxt_zero;
        end
    end

    // Direction registers; other operand values are ignored
    always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            dir_a_ff <= rsx_pkg::DIR_RESET;
            dir_b_ff <= rsx_pkg::DIR_RESET;
        end else if (EXEC && OP == rsx_pkg::OP_DIRLD) begin
            if (FADDR == rsx_pkg::DIR_PORT_A) begin
                dir_a_ff <= acc_ff;
            end
            if (FADDR == rsx_pkg::DIR_PORT_B) begin
                dir_b_ff <= acc_ff;
            end
        end
    end

    // Registered view of the addressed file register
    always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            fdata_ff <= 8'h00;
        end else begin
            fdata_ff <= file_ff[FADDR];
        end
    end

    assign ACC   = acc_ff;
    assign CARRY = carry_ff;
    assign ZERO  = zero_ff;
    assign DIR_A = dir_a_ff;
    assign DIR_B = dir_b_ff;
    assign FDATA = fdata_ff;

    // Rotate result and carry land one edge after the request
    a_rotate_carry: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_RRC && DEST == rsx_pkg::DEST_ACC)
        |=> (acc_ff == {$past(carry_ff), $past(file_ff[FADDR][7:1])})
            && (carry_ff == $past(file_ff[FADDR][0])))
        else $error("rotate result or carry wrong");

    a_dest_file: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_XORF && DEST == rsx_pkg::DEST_FILE)
        |=> $stable(acc_ff))
        else $error("file destination changed accumulator");

    a_swap_flags: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_NSWAP && DEST == rsx_pkg::DEST_ACC)
        |=> acc_ff == {$past(file_ff[FADDR][3:0]), $past(file_ff[FADDR][7:4])}
            && $stable(carry_ff) && $stable(zero_ff))
        else $error("nibble swap wrong");

    a_dir_load: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_DIRLD && FADDR == rsx_pkg::DIR_PORT_B)
        |=> dir_b_ff == $past(acc_ff) && $stable(zero_ff) && $stable(carry_ff))
        else $error("direction load wrong");

    // Operand 6 loads the first direction register and nothing else
    a_dir_a_load: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_DIRLD && FADDR == rsx_pkg::DIR_PORT_A)
        |=> dir_a_ff == $past(acc_ff) && $stable(dir_b_ff)
            && $stable(zero_ff) && $stable(carry_ff))
        else $error("direction load of first port wrong");

    // Operands other than 6 or 7 must leave both direction registers alone
    a_dir_refused: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_DIRLD && FADDR != rsx_pkg::DIR_PORT_A
         && FADDR != rsx_pkg::DIR_PORT_B)
        |=> $stable(dir_a_ff) && $stable(dir_b_ff) && $stable(acc_ff))
        else $error("refused direction load changed state");

    // Rotate into the file: accumulator untouched, carry from old bit 0
    a_rotate_file: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_RRC && DEST == rsx_pkg::DEST_FILE)
        |=> file_ff[$past(FADDR)]
                == {$past(carry_ff), $past(file_ff[FADDR][7:1])}
            && carry_ff == $past(file_ff[FADDR][0]) && $stable(acc_ff))
        else $error("rotate into file wrong");

    // File destination takes the xor result at the addressed entry
    a_file_write: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_XORF && DEST == rsx_pkg::DEST_FILE)
        |=> file_ff[$past(FADDR)]
                == ($past(acc_ff) ^ $past(file_ff[FADDR])))
        else $error("file destination not written");

    a_xor_file: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_XORF && DEST == rsx_pkg::DEST_ACC)
        |=> acc_ff == ($past(acc_ff) ^ $past(file_ff[FADDR]))
            && zero_ff == (acc_ff == 8'h00) && $stable(carry_ff))
        else $error("file xor wrong");

    a_xor_lit: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_XORK)
        |=> acc_ff == ($past(acc_ff) ^ $past(LIT)))
        else $error("immediate xor wrong");

    a_xor_zero: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        (EXEC && OP == rsx_pkg::OP_XORK)
        |=> zero_ff == ($past(acc_ff ^ LIT) == 8'h00))
        else $error("zero flag wrong after immediate xor");

    a_idle_hold: assert property (
        @(posedge REF_CLK) disable iff (!rst_n_ff)
        !EXEC |=> $stable(acc_ff) && $stable(dir_a_ff) && $stable(carry_ff)
                  && $stable(dir_b_ff) && $stable(zero_ff))
        else $error("state changed without request");
endmodule : rsx_core

// ---- bench/rotate_swap_xor_port_direction_load_ops_bench.sv ----
// Self-checking bench for the rotate/swap/xor/direction-load datapath
`timescale 1ns/10ps
module rotate_swap_xor_port_direction_load_ops_bench;
    logic       ref_clk = 1'b0;
    logic       rstn    = 1'b0;
    logic       exec    = 1'b0;
    logic [2:0] op      = 3'h0;
    logic [4:0] faddr   = 5'h00;
    logic       dest    = 1'b0;
    logic [7:0] lit     = 8'h00;
    logic [7:0] acc, dir_a, dir_b, fdata;
    logic       carry, zero;
    logic [7:0] m_acc, m_dira, m_dirb;
    logic       m_c, m_z;
    logic [7:0] m_file [32];
    int         fail_count = 0;
    int         num_checks = 0;

    rsx_core dut (.REF_CLK(ref_clk), .RSTN(rstn), .EXEC(exec), .OP(op),
        .FADDR(faddr), .DEST(dest), .LIT(lit), .ACC(acc), .CARRY(carry),
        .ZERO(zero), .DIR_A(dir_a), .DIR_B(dir_b), .FDATA(fdata));

    // 50 ns period
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // Expected result of one operation
    function automatic logic [7:0] calc(logic [2:0] o, logic [7:0] a,
                                        logic [7:0] f, logic [7:0] k,
                                        logic c);
        case (o)
            rsx_pkg::OP_RRC:   calc = {c, f[7:1]};
            rsx_pkg::OP_NSWAP: calc = {f[3:0], f[7:4]};
            rsx_pkg::OP_XORF:  calc = a ^ f;
            default:           calc = a ^ k;
        endcase
    endfunction : calc

    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic check_all();
        chk("ACC", m_acc, acc);
        chk("CARRY", {7'h00, m_c}, {7'h00, carry});
        chk("ZERO", {7'h00, m_z}, {7'h00, zero});
        chk("DIR_A", m_dira, dir_a);
        chk("DIR_B", m_dirb, dir_b);
        chk("FDATA", m_file[faddr], fdata);
    endtask : check_all

    // Model update for one instruction, in issue order
    task automatic model_op(logic [2:0] o, logic [4:0] fa, logic d,
                            logic [7:0] k);
        logic [7:0] res;
        res = calc(o, m_acc, m_file[fa], k, m_c);
        if (o == rsx_pkg::OP_RRC) m_c = m_file[fa][0];
        if (o == rsx_pkg::OP_XORF || o == rsx_pkg::OP_XORK)
            m_z = (res == 8'h00);
        if (o == rsx_pkg::OP_XORK) m_acc = res;
        if (o == rsx_pkg::OP_DIRLD && fa == 5'h06) m_dira = m_acc;
        if (o == rsx_pkg::OP_DIRLD && fa == 5'h07) m_dirb = m_acc;
        if (o >= 3'h1 && o <= 3'h3) begin
            if (d) m_file[fa] = res;
            else m_acc = res;
        end
    endtask : model_op

    // Put one instruction on the decoder inputs
    task automatic drive_op(logic [2:0] o, logic [4:0] fa, logic d,
                            logic [7:0] k);
        exec  <= 1'b1;
        op    <= o;
        faddr <= fa;
        dest  <= d;
        lit   <= k;
    endtask : drive_op

    // Model update, one instruction pulse, then a settled look
    task automatic run_op(logic [2:0] o, logic [4:0] fa, logic d,
                          logic [7:0] k);
        model_op(o, fa, d, k);
        @(posedge ref_clk);
        drive_op(o, fa, d, k);
        @(posedge ref_clk);
        exec  <= 1'b0;
        // FDATA trails the file by a cycle, so wait one more edge
        @(posedge ref_clk);
        #1;
        check_all();
    endtask : run_op

    // Back-to-back pair: the second sees state left by the first
    task automatic run_pair(logic [2:0] o1, logic [4:0] f1, logic d1,
                            logic [7:0] k1, logic [2:0] o2,
                            logic [4:0] f2, logic d2, logic [7:0] k2);
        model_op(o1, f1, d1, k1);
        model_op(o2, f2, d2, k2);
        @(posedge ref_clk);
        drive_op(o1, f1, d1, k1);
        @(posedge ref_clk);
        drive_op(o2, f2, d2, k2);
        @(posedge ref_clk);
        exec  <= 1'b0;
        // Second write lands one edge later, FDATA one more
        @(posedge ref_clk);
        #1;
        check_all();
    endtask : run_pair

    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog well past the expected 2855 cycles
    initial begin
        repeat (6000) @(posedge ref_clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        m_acc = 8'h00; m_c = 1'b0; m_z = 1'b0;
        m_dira = 8'hFF; m_dirb = 8'hFF;
        foreach (m_file[i]) m_file[i] = 8'h00;
        void'($urandom(17));
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check_all();
        // Corner cases: refused loads, zero result, carry chain
        run_op(rsx_pkg::OP_XORK, 5'h00, 1'b0, 8'hA5);
        run_op(rsx_pkg::OP_DIRLD, 5'h06, 1'b0, 8'h00);
        run_op(rsx_pkg::OP_DIRLD, 5'h05, 1'b0, 8'h00);
        run_op(rsx_pkg::OP_XORF, 5'h1F, 1'b1, 8'h00);
        run_op(rsx_pkg::OP_RRC, 5'h1F, 1'b1, 8'h00);
        run_op(rsx_pkg::OP_NSWAP, 5'h1F, 1'b0, 8'h00);
        run_op(rsx_pkg::OP_DIRLD, 5'h07, 1'b0, 8'h00);
        run_op(rsx_pkg::OP_XORK, 5'h00, 1'b0, m_acc);
        // Back to back: direction load sees the fresh accumulator
        run_pair(rsx_pkg::OP_XORK, 5'h00, 1'b0, 8'h3C,
                 rsx_pkg::OP_DIRLD, 5'h06, 1'b0, 8'h00);
        run_pair(rsx_pkg::OP_RRC, 5'h1F, 1'b1, 8'h00,
                 rsx_pkg::OP_RRC, 5'h1F, 1'b0, 8'h00);
        // Random traffic over every op code and address
        repeat (400) begin
            run_op(3'($urandom_range(0, 7)), 5'($urandom_range(0, 31)),
                   1'($urandom_range(0, 1)), 8'($urandom));
            run_pair(3'($urandom_range(0, 7)), 5'($urandom_range(0, 31)),
                     1'($urandom_range(0, 1)), 8'($urandom),
                     3'($urandom_range(0, 7)), 5'($urandom_range(0, 31)),
                     1'($urandom_range(0, 1)), 8'($urandom));
        end
        wrap_up();
    end
endmodule : rotate_swap_xor_port_direction_load_ops_bench
